/* File: dv/plc_model.sv */
// Model of the downstream safety control and its feedback contact
`timescale 1ns/1ps
`default_nettype none
module plc_model (
	// Clock and command
	input  wire logic clock,
	input  wire logic hold_open,
	// Feedback to the sensor
	output var  logic feedback_closed
);
	// Contact follows the command one cycle late, like a relay
	always @(posedge clock) begin
		feedback_closed <= !hold_open;
	end
endmodule // plc_model
`default_nettype wire

/* File: dv/sensor_chk_sva.sv */
// Assertion checker for the sensor status controller
`timescale 1ns/1ps
`default_nettype none
module sensor_chk (
	// Clock, reset and inputs
	input wire logic clock, sys_rst, actuator_present, actuator_limit, actuator_valid,
	input wire logic teach_active, teach_done, safety_input_a, safety_input_b,
	input wire logic feedback_closed, internal_fault, fault_out_a, fault_out_b,
	input wire logic fault_discrep, warn_temp, warn_ext_volt, warn_cross,
	// Outputs
	input wire logic safety_output_a, safety_output_b, diag_out,
	input wire logic led_green, led_red, led_yellow
);
	wire warn = warn_temp | warn_ext_volt | warn_cross;
	wire off  = !safety_output_a && !safety_output_b;
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	chk_leave_off: assert property ($fell(actuator_present) |=> off)
		else $error("outputs on after actuator left");
	chk_missing_off: assert property (!(safety_input_a && safety_input_b) && !warn |=> off)
		else $error("outputs on with input missing");
	chk_teach_show: assert property (teach_active |=> off && !diag_out && led_red && !led_green)
		else $error("wrong teach indication");
	chk_int_off: assert property (internal_fault |=> off && led_red && !led_green)
		else $error("internal fault not shown");
	chk_int_latch: assert property (internal_fault ##1 (!internal_fault && actuator_present) [*4]
		|-> off)
		else $error("internal error cleared early");
	chk_code_off: assert property (fault_out_a || fault_out_b || fault_discrep |=> off)
		else $error("outputs on during error");
	chk_warn_diag: assert property (warn |=> !diag_out)
		else $error("diag high during warning");
	chk_idle_dark: assert property (!actuator_present && !teach_active && !internal_fault
		|=> !led_yellow)
		else $error("yellow lit without actuator");
	cover property (warn ##1 !diag_out && safety_output_a);
	cover property ($rose(safety_output_a));
	cover property (teach_active ##1 led_red);
endmodule // sensor_chk
bind safety_sensor_status_indicator sensor_chk sensor_chk_i (.*);
`default_nettype wire

/* File: dv/tb_top.sv */
// Self-checking bench for the sensor status controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        clock, sys_rst, hold_open, internal_fault, teach_done;
	logic [11:0] iv;
	logic [24:0] rows [0:15];
	integer      miscompares = 0, compares = 0, cyc = 0, i;
	wire         feedback_closed, sa, sb, diag, grn, red, yel;
	wire  [5:0]  ov = {sa, sb, diag, grn, red, yel};
	safety_sensor_status_indicator #(.WARN_CYCLES(35'h64), .PROT_CYCLES(35'h64))
		safety_sensor_status_indicator_i (.clock(clock), .sys_rst(sys_rst),
		.actuator_present(iv[11]), .actuator_limit(iv[10]), .actuator_valid(iv[9]),
		.teach_active(iv[8]), .teach_done(teach_done), .safety_input_a(iv[7]),
		.safety_input_b(iv[6]), .feedback_closed(feedback_closed),
		.internal_fault(internal_fault), .fault_out_a(iv[5]), .fault_out_b(iv[4]),
		.fault_discrep(iv[3]), .warn_temp(iv[2]), .warn_ext_volt(iv[1]), .warn_cross(iv[0]),
		.safety_output_a(sa), .safety_output_b(sb), .diag_out(diag), .led_green(grn),
		.led_red(red), .led_yellow(yel));
	plc_model plc_model_i (.clock(clock), .hold_open(hold_open),
		.feedback_closed(feedback_closed));
	task automatic check(input logic [5:0] seen, input logic [5:0] exp);
		compares = compares + 1;
		if (seen !== exp) begin
			miscompares = miscompares + 1;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wait_n(input integer n);
		repeat (n) @(negedge clock);
	endtask
	task close_out;
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	// Cycle ceiling against a hang
	always @(posedge clock) begin
		cyc = cyc + 1;
		if (cyc == 2000) begin
			miscompares = miscompares + 1;
			close_out;
		end
	end
	initial begin
		sys_rst = 1'b1;
		iv = 12'h000;
		hold_open = 1'b0;
		internal_fault = 1'b0;
		teach_done = 1'b0;
		// Row: inputs, feedback held open, expected outputs, mask of steady outputs
		rows = '{{12'h2c0, 1'b0, 6'h04, 6'h3f}, {12'hac0, 1'b0, 6'h39, 6'h3f},
			{12'hac4, 1'b0, 6'h31, 6'h3d}, {12'hac0, 1'b0, 6'h39, 6'h3f},
			{12'hac2, 1'b0, 6'h31, 6'h3d}, {12'hac1, 1'b0, 6'h31, 6'h3d},
			{12'hae0, 1'b0, 6'h00, 6'h3c}, {12'had0, 1'b0, 6'h00, 6'h3c},
			{12'hac8, 1'b0, 6'h00, 6'h3c}, {12'h8c0, 1'b0, 6'h00, 6'h3c},
			{12'hac0, 1'b0, 6'h39, 6'h3f}, {12'hac0, 1'b1, 6'h0c, 6'h3e},
			{12'hec0, 1'b0, 6'h30, 6'h36}, {12'h2c0, 1'b0, 6'h04, 6'h3f},
			{12'h280, 1'b0, 6'h00, 6'h33}, {12'hbc0, 1'b0, 6'h02, 6'h3e}};
		wait_n(16);
		sys_rst = 1'b0;
		for (i = 0; i < 16; i = i + 1) begin
			{iv, hold_open} = rows[i][24:12];
			wait_n(3);
			check(ov & rows[i][5:0], rows[i][11:6] & rows[i][5:0]);
		end
		// Internal error holds until the guard opens and closes
		iv = 12'hac0;
		internal_fault = 1'b1;
		wait_n(3);
		check(ov & 6'h36, 6'h02);
		internal_fault = 1'b0;
		wait_n(5);
		check(ov & 6'h30, 6'h00);
		iv[11] = 1'b0;
		wait_n(3);
		iv[11] = 1'b1;
		wait_n(3);
		check(ov & 6'h30, 6'h30);
		// Warning held past its limit
		iv = 12'hac4;
		wait_n(3);
		check(ov & 6'h30, 6'h30);
		wait_n(97);
		check(ov & 6'h30, 6'h30);
		wait_n(1);
		check(ov & 6'h30, 6'h00);
		iv = 12'hac0;
		wait_n(3);
		check(ov & 6'h30, 6'h30);
		// Inhibit interval after a new actuator
		teach_done = 1'b1;
		wait_n(1);
		teach_done = 1'b0;
		wait_n(3);
		check(ov & 6'h30, 6'h00);
		wait_n(105);
		check(ov & 6'h30, 6'h30);
		// Reset in mid-run
		sys_rst = 1'b1;
		wait_n(1);
		check(ov, 6'h00);
		sys_rst = 1'b0;
		wait_n(3);
		check(ov, 6'h39);
		close_out;
	end
endmodule // tb_top
`default_nettype wire

/* File: rtl/safety_sensor_status_indicator.v */
// Status, output and indicator controller of a contactless safety sensor
`timescale 1ns/1ps
`default_nettype none
`include "sensor_status_regs.vh"

module safety_sensor_status_indicator #(
	parameter [34:0] WARN_CYCLES = `WARN_CYC,
	parameter [34:0] PROT_CYCLES = `PROT_CYC
) (
	// Clock and reset
	input  wire       clock,
	input  wire       sys_rst,
	// Sensing
	input  wire       actuator_present,
	input  wire       actuator_limit,
	input  wire       actuator_valid,
	input  wire       teach_active,
	input  wire       teach_done,
	// Safety inputs and feedback
	input  wire       safety_input_a,
	input  wire       safety_input_b,
	input  wire       feedback_closed,
	// Fault sources
	input  wire       internal_fault,
	input  wire       fault_out_a,
	input  wire       fault_out_b,
	input  wire       fault_discrep,
	input  wire       warn_temp,
	input  wire       warn_ext_volt,
	input  wire       warn_cross,
	// Outputs
	output reg        safety_output_a,
	output reg        safety_output_b,
	output reg        diag_out,
	output reg        led_green,
	output reg        led_red,
	output reg        led_yellow
);

	localparam [1:0] ERR_IDLE = 2'b01;
	localparam [1:0] ERR_OPEN = 2'b10;

	reg  [22:0] slow_cnt_q;
	reg         slow_q;
	reg  [20:0] fast_cnt_q;
	reg         fast_q;
	reg  [34:0] warn_cnt_q;
	reg         warn_timeout_q;
	reg  [34:0] prot_cnt_q;
	reg         prot_q;
	reg         int_err_q;
	reg  [1:0]  err_state_q;
	reg  [2:0]  latched_code_q;
	reg  [4:0]  pulse_half_q;
	reg         pulse_on_q;

	wire inputs_ok = safety_input_a & safety_input_b;
	wire warning   = warn_temp | warn_ext_volt | warn_cross;
	wire code_err  = fault_out_a | fault_out_b | fault_discrep | (actuator_present & ~actuator_valid);
	reg  [2:0] code_d;

	// Fault code selection, lowest number first
	always @* begin
		code_d = 3'h0;
		if (fault_out_a)
			code_d = `CODE_OUT_A;
		else if (fault_out_b)
			code_d = `CODE_OUT_B;
		else if (warn_cross)
			code_d = `CODE_CROSS;
		else if (warn_temp)
			code_d = `CODE_TEMP;
		else if (actuator_present & ~actuator_valid)
			code_d = `CODE_ACTUATOR;
		else if (fault_discrep)
			code_d = `CODE_DISCREP;
	end

	// Flash timebases
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			slow_cnt_q <= 23'h0;
			slow_q     <= 1'b0;
			fast_cnt_q <= 21'h0;
			fast_q     <= 1'b0;
		end else begin
			if (slow_cnt_q == `FLASH_HALF_CYC - 1) begin
				slow_cnt_q <= 23'h0;
				slow_q     <= ~slow_q;
			end else begin
				slow_cnt_q <= slow_cnt_q + 23'h1;
			end
			if (fast_cnt_q == `PULSE_HALF_CYC - 1) begin
				fast_cnt_q <= 21'h0;
				fast_q     <= ~fast_q;
			end else begin
				fast_cnt_q <= fast_cnt_q + 21'h1;
			end
		end
	end

	wire fast_tick = (fast_cnt_q == `PULSE_HALF_CYC - 1);

	// Red pulse-count sequencer, code latched per group
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			pulse_half_q   <= 5'h0;
			pulse_on_q     <= 1'b0;
			latched_code_q <= 3'h0;
		end else if (fast_tick) begin
			if (pulse_half_q == 5'h0) begin
				latched_code_q <= code_d;
				pulse_half_q   <= 5'h1;
				pulse_on_q     <= (code_d != 3'h0);
			end else if (pulse_half_q < {1'b0, latched_code_q, 1'b0}) begin
				pulse_half_q <= pulse_half_q + 5'h1;
				pulse_on_q   <= ~pulse_half_q[0];
			end else if (pulse_half_q < {1'b0, latched_code_q, 1'b0} + `CODE_PAUSE_HALVES) begin
				pulse_half_q <= pulse_half_q + 5'h1;
				pulse_on_q   <= 1'b0;
			end else begin
				pulse_half_q <= 5'h0;
				pulse_on_q   <= 1'b0;
			end
		end
	end

	// Warning duration timer
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			warn_cnt_q     <= 35'h0;
			warn_timeout_q <= 1'b0;
		end else if (!warning) begin
			warn_cnt_q     <= 35'h0;
			warn_timeout_q <= 1'b0;
		end else if (warn_cnt_q >= WARN_CYCLES - 1) begin
			warn_timeout_q <= 1'b1;
		end else begin
			warn_cnt_q <= warn_cnt_q + 35'h1;
		end
	end

	// Tamper protection interval; reset models power loss
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			prot_cnt_q <= 35'h0;
			prot_q     <= 1'b0;
		end else if (teach_done) begin
			prot_cnt_q <= 35'h0;
			prot_q     <= 1'b1;
		end else if (prot_q) begin
			if (prot_cnt_q >= PROT_CYCLES - 1)
				prot_q <= 1'b0;
			else
				prot_cnt_q <= prot_cnt_q + 35'h1;
		end
	end

	// Internal error latch, released by guard open then close
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			int_err_q   <= 1'b0;
			err_state_q <= ERR_IDLE;
		end else if (internal_fault) begin
			int_err_q   <= 1'b1;
			err_state_q <= ERR_IDLE;
		end else begin
			case (err_state_q)
				ERR_IDLE: begin
					if (int_err_q && !actuator_present)
						err_state_q <= ERR_OPEN;
				end
				ERR_OPEN: begin
					if (actuator_present) begin
						int_err_q   <= 1'b0;
						err_state_q <= ERR_IDLE;
					end
				end
				default: err_state_q <= ERR_IDLE;
			endcase
		end
	end

	// Output and indicator decode
	reg so_d, diag_d, g_d, r_d, y_d;
	always @* begin
		so_d   = 1'b0;
		diag_d = 1'b0;
		g_d    = 1'b0;
		r_d    = 1'b0;
		y_d    = actuator_present;
		if (teach_active) begin
			r_d = 1'b1;
			y_d = slow_q;
		end else if (int_err_q || internal_fault) begin
			r_d = 1'b1;
			y_d = 1'b0;
		end else if (prot_q || teach_done) begin
			g_d = slow_q;
			y_d = 1'b0;
		end else if (code_err) begin
			r_d = pulse_on_q;
		end else if (warning) begin
			r_d  = (code_d == 3'h0) ? slow_q : pulse_on_q;
			so_d = actuator_present & inputs_ok & ~warn_timeout_q;
		end else if (!inputs_ok) begin
			g_d    = slow_q;
			diag_d = actuator_present;
		end else if (!actuator_present) begin
			g_d = 1'b1;
		end else if (!feedback_closed) begin
			g_d    = 1'b1;
			y_d    = actuator_limit ? slow_q : fast_q;
			diag_d = actuator_limit ? fast_q : 1'b1;
		end else begin
			so_d   = 1'b1;
			diag_d = actuator_limit ? fast_q : 1'b1;
			y_d    = actuator_limit ? slow_q : 1'b1;
		end
	end

	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			safety_output_a <= 1'b0;
			safety_output_b <= 1'b0;
			diag_out        <= 1'b0;
			led_green       <= 1'b0;
			led_red         <= 1'b0;
			led_yellow      <= 1'b0;
		end else begin
			safety_output_a <= so_d & actuator_present;
			safety_output_b <= so_d & actuator_present;
			diag_out        <= diag_d;
			led_green       <= g_d;
			led_red         <= r_d;
			led_yellow      <= y_d;
		end
	end

endmodule // safety_sensor_status_indicator
`default_nettype wire

/* File: rtl/sensor_status_regs.vh */
// Timing counts and fault code values for the sensor status controller
`ifndef SENSOR_STATUS_REGS_VH
`define SENSOR_STATUS_REGS_VH
`define CLK_HZ              10000000
`define FLASH_HZ            1
`define FLASH_HALF_CYC      (`CLK_HZ / (2 * `FLASH_HZ))
`define PULSE_HZ            5
`define PULSE_HALF_CYC      (`CLK_HZ / (2 * `PULSE_HZ))
`define CODE_PAUSE_HALVES   5'h6
`define WARN_MINUTES        30
`define WARN_CYC            35'h430e23400
`define PROT_MINUTES        10
`define PROT_CYC            35'h165a0bc00
`define CODE_OUT_A          3'h1
`define CODE_OUT_B          3'h2
`define CODE_CROSS          3'h3
`define CODE_TEMP           3'h4
`define CODE_ACTUATOR       3'h5
`define CODE_DISCREP        3'h6
`endif
